/* rtl/ciod_alu.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Byte arithmetic for increment, decrement, OR and move
// ==========================================================
module ciod_alu (
  input wire ciod_pkg::ciod_alu_op_t op,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  output logic [7:0] res,
  output ciod_pkg::ciod_flags_t flg
);
  // Decrement adds all ones, so one adder serves both directions
  wire logic [7:0] addend = (op == ciod_pkg::ALU_DEC) ? 8'hff : 8'h01;
  wire logic [8:0] sum = {1'b0, opa} + {1'b0, addend};
  wire logic [4:0] low = {1'b0, opa[3:0]} + {1'b0, addend[3:0]};
  wire logic arith = (op == ciod_pkg::ALU_DEC) || (op == ciod_pkg::ALU_INC);

  // Result selection
  assign res = arith ? sum[7:0] : (op == ciod_pkg::ALU_OR) ? (opa | opb) : opa;

  // Flags; callers mask the ones an instruction may touch
  assign flg.c = sum[8];
  assign flg.dc = low[4];
  assign flg.ov = (opa[7] == addend[7]) && (sum[7] != opa[7]);
  assign flg.z = (res == 8'h00);
  assign flg.n = res[7];
endmodule
`default_nettype wire

/* rtl/ciod_core.sv */
// Summary of operation
// - Decrement and increment file, all five flags
// - Destination bit zero writes W, else file
// - Access bit picks access bank or bank select
// - Extended set, offset up to 95, indexed
// - Skip-if-zero variants keep flags, flush next
// - OR literal into W, N and Z
// - OR W with file, N and Z
// - Move file to destination, N and Z
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ciod_core (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [20:0] FETCH_ADDR,
  input wire logic [15:0] FETCH_DATA,
  output logic [11:0] DM_ADDR,
  output logic [7:0] DM_WDATA,
  output logic DM_WE,
  input wire logic [7:0] DM_RDATA
);
  // ==========================================================
  // State
  // ==========================================================
  ciod_pkg::ciod_phase_t ph_q;       // Current quarter of the cycle
  logic [1:0] ctrl_q;                // Run and extended-set enables
  logic [7:0] wreg_q;                // Working register
  ciod_pkg::ciod_flags_t stat_q;     // Status flags
  logic [3:0] bank_q;                // Bank select register
  logic [11:0] fsr2_q;               // Index base
  logic [20:0] pc_q;                 // Address of the word being fetched
  logic [15:0] ir_q;                 // Instruction now executing
  logic [7:0] res_q;                 // Result captured in the third quarter
  ciod_pkg::ciod_flags_t flg_q;      // Flags captured with the result
  logic [11:0] dm_addr_q;
  logic [7:0] dm_wdata_q;
  logic dm_we_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // ==========================================================
  // Decode
  // ==========================================================
  wire logic [5:0] opc6 = ir_q[15:10];
  wire logic [7:0] fld = ir_q[7:0];
  wire logic dbit = ir_q[9];
  wire logic abit = ir_q[8];
  wire logic run = ctrl_q[ciod_pkg::CTRL_RUN_BIT];
  wire logic ext_en = ctrl_q[ciod_pkg::CTRL_EXT_BIT];

  wire logic is_dec = (opc6 == ciod_pkg::OPC_DECREMENT_FILE_OP);
  wire logic is_inc = (opc6 == ciod_pkg::OPC_INCREMENT_FILE_OP);
  wire logic is_dsz = (opc6 == ciod_pkg::OPC_DECSZ);
  wire logic is_isz = (opc6 == ciod_pkg::OPC_INCSZ);
  wire logic is_dsnz = (opc6 == ciod_pkg::OPC_DECSNZ);
  wire logic is_isnz = (opc6 == ciod_pkg::OPC_INCSNZ);
  wire logic is_or_file_op = (opc6 == ciod_pkg::OPC_OR_FILE_OP);
  wire logic is_move_file_op = (opc6 == ciod_pkg::OPC_MOVE_FILE_OP);
  wire logic is_or_literal_op = (ir_q[15:8] == ciod_pkg::OPC_OR_LITERAL_OP);
  wire logic is_absolute_branch_op = (ir_q[15:8] == ciod_pkg::OPC_ABSOLUTE_BRANCH_OP);

  // Groups by behaviour; anything else executes as a no-op here
  wire logic skip_z = is_dsz | is_isz;
  wire logic skip_nz = is_dsnz | is_isnz;
  wire logic arith = is_dec | is_inc;
  wire logic file_op = arith | skip_z | skip_nz | is_or_file_op | is_move_file_op;
  wire logic down = is_dec | is_dsz | is_dsnz;
  wire logic up = is_inc | is_isz | is_isnz;

  wire ciod_pkg::ciod_alu_op_t alu_op = down ? ciod_pkg::ALU_DEC :
                                        up ? ciod_pkg::ALU_INC :
                                        (is_or_file_op | is_or_literal_op) ? ciod_pkg::ALU_OR :
                                        ciod_pkg::ALU_PASS;

  // Flags each instruction may change
  wire ciod_pkg::ciod_flags_t fmask = arith ? ciod_pkg::MASK_ALL :
    (is_or_file_op | is_or_literal_op | is_move_file_op) ? ciod_pkg::MASK_NZ :
    ciod_pkg::MASK_NONE;

  // Effective data address of the file operand
  function automatic logic [11:0] eff_addr(input logic a, input logic ext,
                                           input logic [7:0] f, input logic [3:0] bank_select_register,
                                           input logic [11:0] base);
    if (a) begin
      eff_addr = {bank_select_register, f};
    end else if (ext && (f <= ciod_pkg::IDX_LIMIT)) begin
      eff_addr = base + {4'h0, f};
    end else if (f < ciod_pkg::ACC_SPLIT) begin
      eff_addr = {4'h0, f};
    end else begin
      eff_addr = {ciod_pkg::ACC_HIGH_BANK, f};
    end
  endfunction

  wire logic [11:0] ea = eff_addr(abit, ext_en, fld, bank_q, fsr2_q);

  // ==========================================================
  // Arithmetic
  // ==========================================================
  // Literal form uses W as first operand and the literal as second
  wire logic [7:0] alu_a = is_or_literal_op ? wreg_q : DM_RDATA;
  wire logic [7:0] alu_res;
  ciod_pkg::ciod_flags_t alu_flg;

  ciod_alu u_alu (
    .op(alu_op),
    .opa(alu_a),
    .opb(is_or_literal_op ? fld : wreg_q),
    .res(alu_res),
    .flg(alu_flg)
  );

  // Skip decision on the captured result
  wire logic res_zero = (res_q == 8'h00);
  wire logic do_skip = (skip_z & res_zero) | (skip_nz & ~res_zero);

  // First-, third- and fourth-quarter strobes, gated by run
  wire logic q4 = run && (ph_q == ciod_pkg::PH_Q4);
  wire logic q3 = run && (ph_q == ciod_pkg::PH_Q3);
  wire logic q1 = run && (ph_q == ciod_pkg::PH_Q1);
  wire logic to_w = q4 && ((file_op && !dbit) || is_or_literal_op);
  wire ciod_pkg::ciod_flags_t stat_nx = (stat_q & ~fmask) | (flg_q & fmask);
  wire logic [20:0] absolute_branch_op_pc = {FETCH_DATA[11:0], fld, 1'b0};

  // ==========================================================
  // APB decode
  // ==========================================================
  wire logic apb_go = PSEL && PENABLE && pready_q;  // Access completes here
  wire logic apb_wr = apb_go && PWRITE;
  wire logic hit_ctrl = (PADDR == ciod_pkg::CTRL_OFS);
  wire logic hit_w = (PADDR == ciod_pkg::WREG_OFS);
  wire logic hit_st = (PADDR == ciod_pkg::STAT_OFS);
  wire logic hit_bk = (PADDR == ciod_pkg::BANK_OFS);
  wire logic hit_fs = (PADDR == ciod_pkg::FSR2_OFS);
  wire logic hit_pc = (PADDR == ciod_pkg::PC_OFS);
  wire logic hit_ir = (PADDR == ciod_pkg::IR_OFS);
  wire logic hit_any = hit_ctrl | hit_w | hit_st | hit_bk | hit_fs | hit_pc | hit_ir;
  wire logic [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_q} :
                             hit_w ? {24'h0, wreg_q} :
                             hit_st ? {27'h0, stat_q} :
                             hit_bk ? {28'h0, bank_q} :
                             hit_fs ? {20'h0, fsr2_q} :
                             hit_pc ? {11'h0, pc_q} :
                             hit_ir ? {16'h0, ir_q} : 32'h0;

  // One wait state, so every answer comes from a flop
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= PSEL && PENABLE && !pready_q;
      prdata_q <= (!PWRITE) ? rd_mux : 32'h0;
      pslverr_q <= !hit_any;  // Unmapped address errors, reads zero
    end
  end

  // Control register; clearing run freezes the phase where it stands
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ctrl_q <= ciod_pkg::CTRL_RST;
    end else if (apb_wr && hit_ctrl) begin
      ctrl_q <= PWDATA[1:0];
    end
  end

  // ==========================================================
  // Phase sequencer
  // ==========================================================
  // Frozen in its quarter while stopped; reset returns it to the first
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ph_q <= ciod_pkg::PH_Q1;
    end else if (run) begin
      unique case (ph_q)
        ciod_pkg::PH_Q1: ph_q <= ciod_pkg::PH_Q2;
        ciod_pkg::PH_Q2: ph_q <= ciod_pkg::PH_Q3;
        ciod_pkg::PH_Q3: ph_q <= ciod_pkg::PH_Q4;
        ciod_pkg::PH_Q4: ph_q <= ciod_pkg::PH_Q1;
        default: ph_q <= ciod_pkg::PH_Q1;
      endcase
    end
  end

  // ==========================================================
  // Data memory side
  // ==========================================================
  // Address set after decode, result captured when data is back
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      dm_addr_q <= 12'h000;
      res_q <= 8'h00;
      flg_q <= ciod_pkg::FLAGS_RST;
    end else begin
      if (q1) begin
        dm_addr_q <= ea;
      end
      if (q3) begin
        res_q <= alu_res;
        flg_q <= alu_flg;
      end
    end
  end

  // Write strobe stands for the whole fourth quarter
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      dm_we_q <= 1'b0;
      dm_wdata_q <= 8'h00;
    end else begin
      dm_we_q <= q3 && file_op && dbit;
      if (q3) begin
        dm_wdata_q <= alu_res;
      end
    end
  end

  // ==========================================================
  // Core registers
  // ==========================================================
  // Core update wins over a software write in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      wreg_q <= ciod_pkg::WREG_RST;
      stat_q <= ciod_pkg::FLAGS_RST;
    end else begin
      if (to_w) begin
        wreg_q <= res_q;
      end else if (apb_wr && hit_w) begin
        wreg_q <= PWDATA[7:0];
      end
      if (q4) begin
        stat_q <= stat_nx;
      end else if (apb_wr && hit_st) begin
        stat_q <= PWDATA[4:0];
      end
    end
  end

  // Bank select and index base are software owned here
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      bank_q <= ciod_pkg::BANK_RST;
      fsr2_q <= ciod_pkg::FSR2_RST;
    end else begin
      if (apb_wr && hit_bk) begin
        bank_q <= PWDATA[3:0];
      end
      if (apb_wr && hit_fs) begin
        fsr2_q <= PWDATA[11:0];
      end
    end
  end

  // Fetch: next word latched at the end of each cycle.
  // A flushed slot becomes a no-op; a second word of a two-word
  // instruction also decodes as a no-op, giving the extra cycle.
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pc_q <= ciod_pkg::PC_RST;
      ir_q <= ciod_pkg::NOP_WORD;
    end else if (q4) begin
      if (is_absolute_branch_op) begin
        pc_q <= absolute_branch_op_pc;
        ir_q <= ciod_pkg::NOP_WORD;
      end else begin
        pc_q <= pc_q + ciod_pkg::PC_STEP;
        ir_q <= do_skip ? ciod_pkg::NOP_WORD : FETCH_DATA;
      end
    end else if (apb_wr && hit_pc && !run) begin
      pc_q <= PWDATA[20:0];
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign FETCH_ADDR = pc_q;
  assign DM_ADDR = dm_addr_q;
  assign DM_WDATA = dm_wdata_q;
  assign DM_WE = dm_we_q;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  chk_dec_result: assert property (
    (q3 && is_dec && dbit) |=> (DM_WE && DM_WDATA == $past(DM_RDATA) - 8'h01))
    else $error("decrement result wrong");
  chk_w_dest: assert property (
    (q3 && file_op && !dbit) |=> !DM_WE ##1 (wreg_q == $past(res_q)))
    else $error("W destination not honoured");
  chk_bank_addr: assert property (
    (q1 && abit) |=> (DM_ADDR == {$past(bank_q), $past(fld)}))
    else $error("banked address wrong");
  chk_index_addr: assert property (
    (q1 && !abit && ext_en && fld <= 8'h5f) |=> (DM_ADDR == $past(fsr2_q) + {4'h0, $past(fld)}))
    else $error("indexed address wrong");
  chk_skipz_flush: assert property (
    (q4 && skip_z && res_zero) |=> (ir_q == 16'h0000 && stat_q == $past(stat_q)))
    else $error("zero skip not taken");
  chk_orlit_w: assert property (
    (q4 && is_or_literal_op) |=> (wreg_q == $past(res_q) && stat_q.c == $past(stat_q.c)))
    else $error("literal OR wrong");
  chk_orfile_flags: assert property (
    (q4 && is_or_file_op) |=> (stat_q.ov == $past(stat_q.ov) && stat_q.z == $past(res_zero)))
    else $error("file OR flags wrong");
  chk_move_zero: assert property (
    (q3 && is_move_file_op) |=> (res_q == $past(DM_RDATA)) ##1 (stat_q.z == (res_q == 8'h00)))
    else $error("move flags wrong");
  chk_skipnz_flush: assert property (
    (q4 && skip_nz && !res_zero) |=> (ir_q == 16'h0000 && stat_q == $past(stat_q)))
    else $error("nonzero skip not taken");
  chk_branch_pc: assert property (
    (q4 && is_absolute_branch_op) |=> (pc_q == $past(absolute_branch_op_pc) && ir_q == 16'h0000)
      ##4 (!run || ir_q == $past(FETCH_DATA)))
    else $error("branch target wrong");

  cov_skip_taken: cover property (q4 && (skip_z | skip_nz) && do_skip);
  cov_absolute_branch_op: cover property (q4 && is_absolute_branch_op);
  cov_indexed: cover property (q1 && !abit && ext_en && fld <= 8'h5f);
  cov_apb_err: cover property (apb_go && !hit_any);
endmodule
`default_nettype wire

/* shared/ciod_pkg.sv */
package ciod_pkg;

  // ==========================================================
  // Register map, byte addresses on the APB slave
  // ==========================================================
  localparam logic [7:0] CTRL_OFS = 8'h00;   // Run and extended-set enables
  localparam logic [7:0] WREG_OFS = 8'h04;   // Working register
  localparam logic [7:0] STAT_OFS = 8'h08;   // Status flags
  localparam logic [7:0] BANK_OFS = 8'h0c;   // Bank select register
  localparam logic [7:0] FSR2_OFS = 8'h10;   // Index base for literal offset mode
  localparam logic [7:0] PC_OFS = 8'h14;     // Program counter
  localparam logic [7:0] IR_OFS = 8'h18;     // Instruction register, read only

  // Field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;

  // ==========================================================
  // Reset values and constants
  // ==========================================================
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [11:0] FSR2_RST = 12'h000;
  localparam logic [20:0] PC_RST = 21'h000000;
  localparam logic [15:0] NOP_WORD = 16'h0000;   // Executes as no operation
  localparam logic [7:0] IDX_LIMIT = 8'h5f;      // Highest indexed offset (95)
  localparam logic [7:0] ACC_SPLIT = 8'h60;      // Low access bank ends here
  localparam logic [3:0] ACC_HIGH_BANK = 4'hf;   // Upper part of access bank, offsets 0x60 to 0xff
  localparam logic [20:0] PC_STEP = 21'h000002;  // Bytes per program word

  // Opcode prefixes
  localparam logic [5:0] OPC_DECREMENT_FILE_OP = 6'b000001;
  localparam logic [5:0] OPC_INCREMENT_FILE_OP = 6'b001010;
  localparam logic [5:0] OPC_DECSZ = 6'b001011;
  localparam logic [5:0] OPC_INCSZ = 6'b001111;
  localparam logic [5:0] OPC_DECSNZ = 6'b010011;
  localparam logic [5:0] OPC_INCSNZ = 6'b010010;
  localparam logic [5:0] OPC_OR_FILE_OP = 6'b000100;
  localparam logic [5:0] OPC_MOVE_FILE_OP = 6'b010100;
  localparam logic [7:0] OPC_OR_LITERAL_OP = 8'h09;
  localparam logic [7:0] OPC_ABSOLUTE_BRANCH_OP = 8'hef;

  // ==========================================================
  // Types
  // ==========================================================
  // Four phases of one instruction cycle
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } ciod_phase_t;

  typedef enum logic [1:0] {
    ALU_PASS = 2'h0,
    ALU_DEC = 2'h1,
    ALU_INC = 2'h2,
    ALU_OR = 2'h3
  } ciod_alu_op_t;

  // Status flags as software sees them, bit 0 is carry
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } ciod_flags_t;

  localparam ciod_flags_t FLAGS_RST = 5'h00;
  localparam ciod_flags_t MASK_ALL = 5'h1f;
  localparam ciod_flags_t MASK_NZ = 5'h14;
  localparam ciod_flags_t MASK_NONE = 5'h00;

endpackage

/* verification/ciod_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ==========================================================
  // Stimulus signals and memory models
  // ==========================================================
  logic core_clk = 1'b0; // 25 MHz core clock
  logic rstn = 1'b0; // Held low for the first 16 edges
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [20:0] fetch_addr;
  logic [15:0] fetch_data;
  logic [11:0] dm_addr;
  logic [7:0] dm_wdata;
  logic dm_we;
  logic [7:0] dm_rdata;
  logic [7:0] dm [0:4095]; // Data memory, combinational read
  logic [15:0] pm [0:31]; // Program memory, beyond it reads as no-op
  logic [32:0] exp_q [$]; // Read notes, error bit on top
  logic [32:0] note;
  int mismatches = 0;
  int samples_checked = 0;
  integer seed = 32'hdbce;

  // ==========================================================
  // Clock, memories and design
  // ==========================================================
  always #20 core_clk = ~core_clk;
  assign dm_rdata = dm[dm_addr];
  assign fetch_data = (fetch_addr[20:6] == 15'h0000) ? pm[fetch_addr[5:1]] : 16'h0000;
  // Memory write lands at the edge closing the write phase
  always @(posedge core_clk) begin
    if (dm_we === 1'b1) begin
      dm[dm_addr] <= dm_wdata;
    end
  end

  ciod_core u_dut (.CORE_CLK(core_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FETCH_ADDR(fetch_addr), .FETCH_DATA(fetch_data), .DM_ADDR(dm_addr),
    .DM_WDATA(dm_wdata), .DM_WE(dm_we), .DM_RDATA(dm_rdata));

  // ==========================================================
  // Reporting
  // ==========================================================
  task check(input logic [32:0] got, input logic [32:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task complete_run;
    $display("Counts: %0d compared, %0d mismatches", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task give_up(input string what);
    mismatches++;
    $display("wrong value at %0t: timeout in %s", $time, what);
    complete_run();
  endtask

  // Monitor: pre-edge values, so the completing edge is seen exactly once
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) begin
        check({pslverr, prdata}, 33'h1ffffffff, "unexpected read");
      end else begin
        note = exp_q.pop_front();
        check({pslverr, prdata}, note, "read data");
      end
    end
  end

  // ==========================================================
  // APB master: hold the request until ready is seen at an edge
  // ==========================================================
  task apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    // Ready is read as sampled at each rising edge; release follows that same edge
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) give_up("apb");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [7:0] adr, input logic [31:0] exp, input logic err);
    exp_q.push_back({err, exp});
    apb(1'b0, adr, 32'h0000_0000);
  endtask

  // ==========================================================
  // One instruction, then a two-word branch that a skip must discard
  // ==========================================================
  task run_case(input int op);
    logic [7:0] f, v, w, k, r;
    logic [4:0] st, nst;
    logic [3:0] bank_select_register;
    logic [11:0] fsr, adr;
    logic [31:0] ctl;
    logic d, a, ext, skip, to_w, dec;
    logic [5:0] pre;
    int n;
    f = 8'($random(seed));
    w = 8'($random(seed));
    k = 8'($random(seed));
    st = 5'($random(seed));
    bank_select_register = 4'($random(seed));
    fsr = 12'({$random(seed)} % 3584);
    {d, a, ext} = 3'($random(seed));
    // Boundary operands half of the time
    v = ($random(seed) & 1) ? 8'($random(seed)) : ((f[0]) ? 8'h00 : (f[1] ? 8'h80 : 8'hff));
    if (op < 2 && f[2]) v = (op == 0) ? 8'h01 : 8'h7f;
    adr = a ? {bank_select_register, f} : (ext && f <= ciod_pkg::IDX_LIMIT) ? fsr + 12'(f) :
      (f < ciod_pkg::ACC_SPLIT) ? {4'h0, f} : {ciod_pkg::ACC_HIGH_BANK, f};
    dm[adr] = v;
    dec = (op == 0 || op == 2 || op == 4);
    case (op)
      0: pre = ciod_pkg::OPC_DECREMENT_FILE_OP;
      1: pre = ciod_pkg::OPC_INCREMENT_FILE_OP;
      2: pre = ciod_pkg::OPC_DECSZ;
      3: pre = ciod_pkg::OPC_INCSZ;
      4: pre = ciod_pkg::OPC_DECSNZ;
      5: pre = ciod_pkg::OPC_INCSNZ;
      6: pre = ciod_pkg::OPC_OR_FILE_OP;
      default: pre = ciod_pkg::OPC_MOVE_FILE_OP;
    endcase
    r = (op < 6) ? (dec ? v - 8'h01 : v + 8'h01) : (op == 6) ? (w | v) : (op == 7) ? v : (w | k);
    skip = (op == 2 || op == 3) ? (r == 8'h00) : (op == 4 || op == 5) ? (r != 8'h00) : 1'b0;
    nst = st;
    // Order n, ov, z, dc, c; borrow reads as carry clear
    if (op < 2) nst = {r[7], dec ? v == 8'h80 : v == 8'h7f, r == 8'h00,
      dec ? v[3:0] != 4'h0 : v[3:0] == 4'hf, dec ? v != 8'h00 : v == 8'hff};
    if (op > 5) nst = {r[7], st[3], r == 8'h00, st[1:0]};
    to_w = (op == 8) || !d;
    foreach (pm[i]) pm[i] = 16'h0000;
    pm[0] = (op == 8) ? {ciod_pkg::OPC_OR_LITERAL_OP, k} : {pre, d, a, f};
    pm[1] = {ciod_pkg::OPC_ABSOLUTE_BRANCH_OP, 8'h05};
    pm[2] = 16'hf000;
    pm[3] = {ciod_pkg::OPC_ABSOLUTE_BRANCH_OP, 8'h03};
    pm[4] = 16'hf000;
    pm[5] = {ciod_pkg::OPC_ABSOLUTE_BRANCH_OP, 8'h05};
    pm[6] = 16'hf000;
    // A fresh reset per case, applied while the core is stopped with run clear
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    apb(1'b1, ciod_pkg::WREG_OFS, {24'h0, w});
    apb(1'b1, ciod_pkg::STAT_OFS, {27'h0, st});
    apb(1'b1, ciod_pkg::BANK_OFS, {28'h0, bank_select_register});
    apb(1'b1, ciod_pkg::FSR2_OFS, {20'h0, fsr});
    ctl = 32'h0000_0000;
    ctl[ciod_pkg::CTRL_EXT_BIT] = ext;
    ctl[ciod_pkg::CTRL_RUN_BIT] = 1'b1;
    apb(1'b1, ciod_pkg::CTRL_OFS, ctl);
    apb(1'b1, ciod_pkg::PC_OFS, 32'h0000_0100); // Must be ignored while running
    n = 0;
    while (!(fetch_addr >= 21'h6 && fetch_addr <= 21'hc) && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 200) give_up("program run");
    repeat (16) @(posedge core_clk); // Four instruction cycles of settling
    check({32'h0, fetch_addr inside {21'h6, 21'h8}}, {32'h0, skip}, "skip");
    ctl[ciod_pkg::CTRL_RUN_BIT] = 1'b0;
    apb(1'b1, ciod_pkg::CTRL_OFS, ctl);
    rd(ciod_pkg::WREG_OFS, {24'h0, to_w ? r : w}, 1'b0);
    rd(ciod_pkg::STAT_OFS, {27'h0, nst}, 1'b0);
    rd(ciod_pkg::BANK_OFS, {28'h0, bank_select_register}, 1'b0);
    check({25'h0, dm[adr]}, {25'h0, to_w ? v : r}, "file");
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    foreach (dm[i]) dm[i] = 8'($random(seed));
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    rd(ciod_pkg::CTRL_OFS, {30'h0, ciod_pkg::CTRL_RST}, 1'b0);
    rd(ciod_pkg::WREG_OFS, {24'h0, ciod_pkg::WREG_RST}, 1'b0);
    rd(ciod_pkg::STAT_OFS, {27'h0, ciod_pkg::FLAGS_RST}, 1'b0);
    rd(ciod_pkg::BANK_OFS, {28'h0, ciod_pkg::BANK_RST}, 1'b0);
    rd(ciod_pkg::FSR2_OFS, {20'h0, ciod_pkg::FSR2_RST}, 1'b0);
    rd(ciod_pkg::PC_OFS, {11'h0, ciod_pkg::PC_RST}, 1'b0);
    apb(1'b1, ciod_pkg::IR_OFS, 32'h0000_1234); // Read-only place
    rd(ciod_pkg::IR_OFS, {16'h0, ciod_pkg::NOP_WORD}, 1'b0);
    rd(8'h1c, 32'h0000_0000, 1'b1); // Unmapped
    $display("Reset values and map checked");
    for (int op = 0; op < 9; op++) begin
      for (int rep = 0; rep < 8; rep++) begin
        run_case(op);
      end
      $display("Operation %0d checked", op);
    end
    @(posedge core_clk);
    check({1'b0, 32'(exp_q.size())}, 33'h0, "pending reads");
    complete_run();
  end
endmodule
`default_nettype wire
